// File: logic/spr_pkg.sv
/*
 * Constants for the step-1/step-2 light-diode routing register bank:
 * register indices, field positions, reset values and routing codes.
 * Assumes one bus word per register, byte address = 4 * index.
 */
package spr_pkg;

	localparam int SPR_IDX_W = 8;
	localparam int SPR_DIODES = 6;
	localparam int SPR_MODS = 3;
	localparam int SPR_CODE_W = 2;
	localparam int SPR_ROUTE_W = SPR_DIODES * SPR_CODE_W;
	localparam int SPR_GAIN_W = 4;
	localparam int SPR_STEPS = 4;

	// register indices
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S1_GAIN_LOW = 8'hd6;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S1_GAIN_HIGH = 8'hd7;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S2_GAIN_LOW = 8'hd8;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S2_GAIN_HIGH = 8'hd9;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S1_ROUTE_LOW = 8'hde;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S1_ROUTE_HIGH = 8'hdf;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S2_ROUTE_LOW = 8'he0;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_S2_ROUTE_HIGH = 8'he1;
	localparam logic [SPR_IDX_W-1:0] SPR_IDX_STATUS = 8'hf0;

	// reset values
	localparam logic [7:0] SPR_RST_S1_ROUTE_LOW = 8'h84;
	localparam logic [7:0] SPR_RST_S1_ROUTE_HIGH = 8'hf3;
	localparam logic [7:0] SPR_RST_S2_ROUTE_LOW = 8'h07;
	localparam logic [7:0] SPR_RST_S2_ROUTE_HIGH = 8'hf8;
	localparam logic [7:0] SPR_RST_GAIN_LOW = 8'h88;
	localparam logic [7:0] SPR_RST_GAIN_HIGH = 8'h08;
	localparam logic [SPR_GAIN_W-1:0] SPR_GAIN_RST = 4'h8;

	// field positions inside the high routing and gain registers
	localparam int SPR_MASK_LSB = 4;
	localparam int SPR_MASK_W = 4;
	localparam int SPR_HIGH_ROUTE_W = 4;
	localparam int SPR_GAIN_HIGH_W = 4;
	// status register fields
	localparam int SPR_STAT_ACTIVE = 0;
	localparam int SPR_STAT_STEP_LSB = 1;
	localparam int SPR_STAT_VALID = 3;

	// routing codes
	localparam logic [SPR_CODE_W-1:0] SPR_CODE_NONE = 2'h0;
	localparam logic [SPR_CODE_W-1:0] SPR_CODE_MOD0 = 2'h1;
	localparam logic [SPR_CODE_W-1:0] SPR_CODE_MOD1 = 2'h2;
	localparam logic [SPR_CODE_W-1:0] SPR_CODE_MOD2 = 2'h3;

	localparam logic [1:0] SPR_STEP1 = 2'h1;
	localparam logic [1:0] SPR_STEP2 = 2'h2;

endpackage : spr_pkg

// File: logic/spr_diode_router_regs.sv
/*
 * Routing and gain-control configuration bank for measurement_stepper
 * steps 1 and 2, a classic Wishbone slave, plus the per-step latch that
 * presents the configuration of the running step to the analog side.
 * Assumes step_start/step_end come from the measurement_stepper on ref_clk.
 */
`timescale 1ns/1ps
module spr_diode_router_regs
	import spr_pkg::*;
#(
	parameter int ADR_W = 10
)
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic step_start,
	input wire logic [1:0] step_index,
	input wire logic step_end,
	output logic step_active,
	output logic route_valid,
	output logic [SPR_DIODES-1:0] mod0_diodes,
	output logic [SPR_DIODES-1:0] mod1_diodes,
	output logic [SPR_DIODES-1:0] mod2_diodes,
	output logic [SPR_GAIN_W-1:0] mod0_gain,
	output logic [SPR_GAIN_W-1:0] mod1_gain,
	output logic [SPR_GAIN_W-1:0] mod2_gain,
	output logic saturation_gain_en,
	output logic predictive_gain_en
);

	localparam int REG_W = 8; // one byte of each bus word is a register
	// index sits above the two byte-lane bits, so the address must reach that far
	if (ADR_W < SPR_IDX_W + 2)
	begin : g_bad_adr_w
		$error("spr_diode_router_regs: ADR_W too small for the register map");
	end
	// the step mask shares the high byte with the two upper diode fields
	if (SPR_MASK_LSB != SPR_HIGH_ROUTE_W || SPR_MASK_LSB + SPR_MASK_W != REG_W)
	begin : g_bad_high_layout
		$error("spr_diode_router_regs: high routing byte layout does not fit");
	end
	// one mask bit per step, one code per modulator plus the unconnected code
	if (SPR_MASK_W != SPR_STEPS || (1 << SPR_CODE_W) != SPR_MODS + 1)
	begin : g_bad_code_map
		$error("spr_diode_router_regs: mask or routing code width does not fit");
	end
	if (SPR_ROUTE_W != REG_W + SPR_HIGH_ROUTE_W)
	begin : g_bad_route_w
		$error("spr_diode_router_regs: route width does not match the two registers");
	end

	logic [7:0] s1_route_low, s1_route_high, s2_route_low, s2_route_high;
	logic [7:0] s1_gain_low, s1_gain_high, s2_gain_low, s2_gain_high;
	logic [7:0] next_s1_route_low, next_s1_route_high;
	logic [7:0] next_s2_route_low, next_s2_route_high;
	logic [7:0] next_s1_gain_low, next_s1_gain_high;
	logic [7:0] next_s2_gain_low, next_s2_gain_high;
	logic [31:0] next_dat;
	logic next_ack;
	logic [1:0] cur_step, next_cur_step;
	logic next_active, next_valid, next_sat, next_pred;
	logic [SPR_DIODES-1:0] next_m0, next_m1, next_m2;
	logic [SPR_GAIN_W-1:0] next_g0, next_g1, next_g2;

	logic [SPR_IDX_W-1:0] idx;
	logic wr_take;
	logic [SPR_ROUTE_W-1:0] s1_route, s2_route, sel_route;
	logic [SPR_MASK_W-1:0] sat_mask, pred_mask;
	logic [SPR_DIODES-1:0] pick_m0, pick_m1, pick_m2;
	logic [7:0] sel_gain_low, sel_gain_high;
	logic sel_owned;

	assign idx = wb_adr_i[SPR_IDX_W+1:2];
	// write lands on the edge where ack is seen high by the master; only byte lane 0
	// holds a register, so a write without that lane is dropped
	assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	// route vectors: diode d at bits 2d+1:2d, upper diodes above the low byte
	assign s1_route = {s1_route_high[SPR_HIGH_ROUTE_W-1:0], s1_route_low};
	assign s2_route = {s2_route_high[SPR_HIGH_ROUTE_W-1:0], s2_route_low};
	assign sat_mask = s1_route_high[SPR_MASK_LSB +: SPR_MASK_W];
	assign pred_mask = s2_route_high[SPR_MASK_LSB +: SPR_MASK_W];

	// bus side: register writes and read data
	always_comb
	begin
		next_s1_route_low = s1_route_low;
		next_s1_route_high = s1_route_high;
		next_s2_route_low = s2_route_low;
		next_s2_route_high = s2_route_high;
		next_s1_gain_low = s1_gain_low;
		next_s1_gain_high = s1_gain_high;
		next_s2_gain_low = s2_gain_low;
		next_s2_gain_high = s2_gain_high;
		// registered ack drops after one cycle; a master that does not gap is answered twice
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_dat = wb_dat_o;
		if (wr_take)
		begin
			if (idx == SPR_IDX_S1_ROUTE_LOW)
				next_s1_route_low = wb_dat_i[7:0];
			else if (idx == SPR_IDX_S1_ROUTE_HIGH)
				next_s1_route_high = wb_dat_i[7:0];
			else if (idx == SPR_IDX_S2_ROUTE_LOW)
				next_s2_route_low = wb_dat_i[7:0];
			else if (idx == SPR_IDX_S2_ROUTE_HIGH)
				next_s2_route_high = wb_dat_i[7:0];
			else if (idx == SPR_IDX_S1_GAIN_LOW)
				next_s1_gain_low = wb_dat_i[7:0];
			// reserved gain-high bits never store, so they read back as zero
			else if (idx == SPR_IDX_S1_GAIN_HIGH)
				next_s1_gain_high = {4'h0, wb_dat_i[SPR_GAIN_HIGH_W-1:0]};
			else if (idx == SPR_IDX_S2_GAIN_LOW)
				next_s2_gain_low = wb_dat_i[7:0];
			else if (idx == SPR_IDX_S2_GAIN_HIGH)
				next_s2_gain_high = {4'h0, wb_dat_i[SPR_GAIN_HIGH_W-1:0]};
		end
		if (next_ack && !wb_we_i)
		begin
			if (idx == SPR_IDX_S1_ROUTE_LOW)
				next_dat = {24'h0, s1_route_low};
			else if (idx == SPR_IDX_S1_ROUTE_HIGH)
				next_dat = {24'h0, s1_route_high};
			else if (idx == SPR_IDX_S2_ROUTE_LOW)
				next_dat = {24'h0, s2_route_low};
			else if (idx == SPR_IDX_S2_ROUTE_HIGH)
				next_dat = {24'h0, s2_route_high};
			else if (idx == SPR_IDX_S1_GAIN_LOW)
				next_dat = {24'h0, s1_gain_low};
			else if (idx == SPR_IDX_S1_GAIN_HIGH)
				next_dat = {24'h0, s1_gain_high};
			else if (idx == SPR_IDX_S2_GAIN_LOW)
				next_dat = {24'h0, s2_gain_low};
			else if (idx == SPR_IDX_S2_GAIN_HIGH)
				next_dat = {24'h0, s2_gain_high};
			else if (idx == SPR_IDX_STATUS)
				next_dat = {28'h0, route_valid, cur_step, step_active};
			else
				next_dat = 32'h0;
		end
		else if (next_ack)
			next_dat = 32'h0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s1_route_low <= SPR_RST_S1_ROUTE_LOW;
			s1_route_high <= SPR_RST_S1_ROUTE_HIGH;
			s2_route_low <= SPR_RST_S2_ROUTE_LOW;
			s2_route_high <= SPR_RST_S2_ROUTE_HIGH;
			s1_gain_low <= SPR_RST_GAIN_LOW;
			s1_gain_high <= SPR_RST_GAIN_HIGH;
			s2_gain_low <= SPR_RST_GAIN_LOW;
			s2_gain_high <= SPR_RST_GAIN_HIGH;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else if (clk_en)
		begin
			s1_route_low <= next_s1_route_low;
			s1_route_high <= next_s1_route_high;
			s2_route_low <= next_s2_route_low;
			s2_route_high <= next_s2_route_high;
			s1_gain_low <= next_s1_gain_low;
			s1_gain_high <= next_s1_gain_high;
			s2_gain_low <= next_s2_gain_low;
			s2_gain_high <= next_s2_gain_high;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// route and gains of the requested step; steps 0 and 3 belong to a neighbouring
	// bank, so this one offers no route and the reset gain for them
	always_comb
	begin
		sel_route = '0;
		sel_gain_low = SPR_RST_GAIN_LOW;
		sel_gain_high = SPR_RST_GAIN_HIGH;
		sel_owned = 1'b0;
		if (step_index == SPR_STEP1)
		begin
			sel_route = s1_route;
			sel_gain_low = s1_gain_low;
			sel_gain_high = s1_gain_high;
			sel_owned = 1'b1;
		end
		else if (step_index == SPR_STEP2)
		begin
			sel_route = s2_route;
			sel_gain_low = s2_gain_low;
			sel_gain_high = s2_gain_high;
			sel_owned = 1'b1;
		end
	end

	// per-diode decode: one code per diode, so a diode never feeds two modulators
	for (genvar d = 0; d < SPR_DIODES; d++)
	begin : g_diode
		logic [SPR_CODE_W-1:0] field;
		assign field = sel_route[d*SPR_CODE_W +: SPR_CODE_W];
		assign pick_m0[d] = (field == SPR_CODE_MOD0);
		assign pick_m1[d] = (field == SPR_CODE_MOD1);
		assign pick_m2[d] = (field == SPR_CODE_MOD2);
	end

	// step side: snapshot at step start so mid-step writes cannot glitch the analog path
	always_comb
	begin
		next_cur_step = cur_step;
		next_active = step_active;
		next_valid = route_valid;
		next_sat = saturation_gain_en;
		next_pred = predictive_gain_en;
		next_m0 = mod0_diodes;
		next_m1 = mod1_diodes;
		next_m2 = mod2_diodes;
		next_g0 = mod0_gain;
		next_g1 = mod1_gain;
		next_g2 = mod2_gain;
		if (step_start)
		begin
			next_cur_step = step_index;
			next_active = 1'b1;
			next_valid = sel_owned;
			next_sat = sat_mask[step_index];
			next_pred = pred_mask[step_index];
			next_m0 = pick_m0;
			next_m1 = pick_m1;
			next_m2 = pick_m2;
			next_g0 = sel_gain_low[SPR_GAIN_W-1:0];
			next_g1 = sel_gain_low[2*SPR_GAIN_W-1:SPR_GAIN_W];
			next_g2 = sel_gain_high[SPR_GAIN_W-1:0];
		end
		else if (step_end)
		begin
			// routing and gains stay put until the next start; only step_active and the two gain enables drop
			next_active = 1'b0;
			next_sat = 1'b0;
			next_pred = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cur_step <= 2'h0;
			step_active <= 1'b0;
			route_valid <= 1'b0;
			saturation_gain_en <= 1'b0;
			predictive_gain_en <= 1'b0;
			mod0_diodes <= '0;
			mod1_diodes <= '0;
			mod2_diodes <= '0;
			mod0_gain <= SPR_GAIN_RST;
			mod1_gain <= SPR_GAIN_RST;
			mod2_gain <= SPR_GAIN_RST;
		end
		else if (clk_en)
		begin
			cur_step <= next_cur_step;
			step_active <= next_active;
			route_valid <= next_valid;
			saturation_gain_en <= next_sat;
			predictive_gain_en <= next_pred;
			mod0_diodes <= next_m0;
			mod1_diodes <= next_m1;
			mod2_diodes <= next_m2;
			mod0_gain <= next_g0;
			mod1_gain <= next_g1;
			mod2_gain <= next_g2;
		end
	end

endmodule : spr_diode_router_regs

// File: tb/spr_diode_router_regs_sva.sv
/*
 checker for spr_diode_router_regs: bus answer and step latch timing.
 sees only top ports; bound from the bench top file.
*/
`timescale 1ns/1ps
module spr_diode_router_regs_sva
	import spr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic step_start,
	input wire logic [1:0] step_index,
	input wire logic step_end,
	input wire logic step_active,
	input wire logic route_valid,
	input wire logic [SPR_DIODES-1:0] mod0_diodes,
	input wire logic [SPR_DIODES-1:0] mod1_diodes,
	input wire logic [SPR_DIODES-1:0] mod2_diodes,
	input wire logic [SPR_GAIN_W-1:0] mod0_gain,
	input wire logic saturation_gain_en,
	input wire logic predictive_gain_en
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_pulse: assert property (s_req |=> s_ans)
		else $error("ack late or longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_read_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_start_active: assert property (step_start |=> step_active)
		else $error("step not active after start");
	a_valid_kind: assert property (step_start |=>
		route_valid == ($past(step_index) inside {2'h1, 2'h2}))
		else $error("route valid wrong for step");
	a_end_clear: assert property (step_end && !step_start |=>
		!(step_active || saturation_gain_en || predictive_gain_en))
		else $error("step end did not clear");
	a_route_hold: assert property (!step_start |=> $stable(mod0_diodes) && $stable(mod0_gain))
		else $error("step outputs moved without start");
	a_idle_gain: assert property (!step_active |-> !(saturation_gain_en || predictive_gain_en))
		else $error("gain enable outside step");
	a_diode_one_mod: assert property (!(|(mod0_diodes & mod1_diodes))
		&& !(|(mod0_diodes & mod2_diodes)) && !(|(mod1_diodes & mod2_diodes)))
		else $error("diode routed to two modulators");
	a_foreign_dark: assert property (!route_valid |->
		!(|{mod0_diodes, mod1_diodes, mod2_diodes}))
		else $error("diodes routed for a step this bank does not own");
endmodule : spr_diode_router_regs_sva

// File: tb/spr_diode_router_regs_tb_top.sv
/*
 bench for spr_diode_router_regs: wishbone master, stepper pulses, random
 route and gain values. assumes spr_pkg and the checker compiled first.
*/
`timescale 1ns/1ps
module spr_diode_router_regs_tb_top
	import spr_pkg::*;
;
	logic ref_clk = 0;
	logic sys_rst = 1;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic st = 0;
	logic se = 0;
	logic [1:0] si = 0;
	logic [9:0] adr = 0;
	logic [31:0] dat = 0;
	logic [31:0] rd;
	logic ack, act, val, sat, prd;
	logic [5:0] m0, m1, m2;
	logic [3:0] g0, g1, g2;
	logic [7:0] rg [8];
	logic [7:0] nrg [8];
	logic [7:0] q, d;
	int mismatches = 0;
	int total_checks = 0;
	always #50 ref_clk = ~ref_clk;
	spr_diode_router_regs uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .step_start(st), .step_index(si),
		.step_end(se), .step_active(act), .route_valid(val), .mod0_diodes(m0),
		.mod1_diodes(m1), .mod2_diodes(m2), .mod0_gain(g0), .mod1_gain(g1),
		.mod2_gain(g2), .saturation_gain_en(sat), .predictive_gain_en(prd));
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// route lows/highs of steps 1 and 2, then gain lows/highs of steps 1 and 2
	function automatic logic [7:0] ix(input int j);
		ix = 8'(j < 4 ? 8'hde + j : 8'hd6 + j - 4);
	endfunction : ix
	// gain-high bits 7:4 are reserved and read back as zero
	function automatic logic [7:0] kept(input int j, input logic [7:0] v);
		kept = j == 5 || j == 7 ? {4'h0, v[3:0]} : v;
	endfunction : kept
	function automatic logic [5:0] dm(input logic [11:0] r, input logic [1:0] c);
		for (int j = 0; j < 6; j++)
			dm[j] = r[2*j+:2] == c;
	endfunction : dm
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] v);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {i, 2'h0};
		dat <= {24'h0, v};
		do @(posedge ref_clk); while (ack !== 1'b1);
		q = rd[7:0];
		cyc <= 0;
		stb <= 0;
		@(posedge ref_clk);
	endtask : wb
	task automatic pulse(input logic e, input logic [1:0] k);
		st <= !e;
		se <= e;
		si <= k;
		@(posedge ref_clk);
		st <= 0;
		se <= 0;
		@(posedge ref_clk);
	endtask : pulse
	task automatic ck(input logic [1:0] k);
		logic [11:0] r;
		logic v;
		logic [7:0] g, h;
		r = k[0] ? {rg[1][3:0], rg[0]} : {rg[3][3:0], rg[2]};
		v = k == 2'h1 || k == 2'h2;
		g = k == 2'h1 ? rg[4] : k == 2'h2 ? rg[6] : 8'h88;
		h = k == 2'h1 ? rg[5] : k == 2'h2 ? rg[7] : 8'h08;
		chk("active", 8'h1, act);
		chk("valid", v, val);
		chk("mod0", v ? dm(r, 2'h1) : 6'h0, m0);
		chk("mod1", v ? dm(r, 2'h2) : 6'h0, m1);
		chk("mod2", v ? dm(r, 2'h3) : 6'h0, m2);
		chk("gain0", g[3:0], g0);
		chk("gain1", g[7:4], g1);
		chk("gain2", h[3:0], g2);
		chk("sat", rg[1][4+k], sat);
		chk("pred", rg[3][4+k], prd);
	endtask : ck
	task automatic rst;
		sys_rst <= 1;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 0;
		rg = '{8'h84, 8'hf3, 8'h07, 8'hf8, 8'h88, 8'h08, 8'h88, 8'h08};
		@(posedge ref_clk);
		for (int j = 0; j < 8; j++)
		begin
			wb(0, ix(j), 8'h0);
			chk("reset", rg[j], q);
		end
	endtask : rst
	initial
	begin
		void'($urandom(4875));
		rst;
		wb(0, 8'h50, 8'h0);
		chk("unmapped", 8'h0, q);
		// data changes mid-step to prove the latch holds the old set
		for (int i = 0; i < 24; i++)
		begin
			pulse(0, i[1:0]);
			ck(i[1:0]);
			for (int j = 0; j < 8; j++)
			begin
				d = 8'($urandom);
				wb(1, ix(j), d);
				wb(0, ix(j), 8'h0);
				chk("readback", kept(j, d), q);
				nrg[j] = kept(j, d);
			end
			ck(i[1:0]);
			pulse(1, 2'h0);
			chk("end", 8'h0, act | sat | prd);
			rg = nrg;
		end
		rst;
		pulse(0, 2'h1);
		ck(2'h1);
		final_report;
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		final_report;
	end
endmodule : spr_diode_router_regs_tb_top
bind spr_diode_router_regs spr_diode_router_regs_sva u_sva (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .step_start(step_start), .step_index(step_index),
	.step_end(step_end), .step_active(step_active), .route_valid(route_valid),
	.mod0_diodes(mod0_diodes), .mod1_diodes(mod1_diodes), .mod2_diodes(mod2_diodes),
	.mod0_gain(mod0_gain),
	.saturation_gain_en(saturation_gain_en), .predictive_gain_en(predictive_gain_en));
